// ### tfr_pkg.sv
// Package with the command map, field layout and shared types of the temperature fault response.
package tfr_pkg;

    // ================================================================
    // Command codes
    localparam logic [7:0] CMD_OPERATION   = 8'h01;
    localparam logic [7:0] CMD_CLEAR       = 8'h03;
    localparam logic [7:0] CMD_EXT_OT      = 8'h50;
    localparam logic [7:0] CMD_EXT_UT      = 8'h54;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
    localparam logic [7:0] CMD_STATUS_MFR  = 8'h80;
    localparam logic [7:0] CMD_INT_OT      = 8'hd6;

    // ================================================================
    // Reset values
    localparam logic [7:0] EXT_ACT_RESET = 8'hb8;
    localparam logic [7:0] INT_ACT_RESET = 8'hc0;
    localparam logic       OP_ON_RESET   = 1'b1;

    // ================================================================
    // Field positions
    localparam int RESP_HI   = 7;
    localparam int RESP_LO   = 6;
    localparam int RETRY_HI  = 5;
    localparam int RETRY_LO  = 3;
    localparam int OP_ON_BIT = 7;
    localparam int SB_TEMP   = 2;
    localparam int SB_CML    = 1;
    localparam int SB_NOA    = 0;
    localparam int ST_OT     = 7;
    localparam int ST_UT     = 6;
    localparam int SM_OT     = 1;

    // ================================================================
    // Field codes
    localparam logic [1:0] RESP_CONTINUE = 2'h0;
    localparam logic [1:0] RESP_BAD      = 2'h1;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] RESP_WHILE    = 2'h3;
    localparam logic [2:0] RETRY_NONE    = 3'h0;

    // ================================================================
    // Timing: one restart interval unit, and the clock rate.
    localparam int RETRY_UNIT_US = 1000;
    localparam int CLK_MHZ       = 10;
    localparam int RETRY_UNIT_CYC = RETRY_UNIT_US * CLK_MHZ;
    localparam int SYNC_W        = 3;

    // Alert mask bits.
    localparam int MASK_CML = 0;
    localparam int MASK_INT = 1;
    localparam int MASK_OT  = 2;
    localparam int MASK_UT  = 3;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       page;
        logic [7:0] code;
        logic [7:0] data;
    } tfr_cmd_s;

    typedef struct packed {
        logic       cml;
        logic       catch_all_status_flag;
        logic       temp_summary;
        logic       mfr_summary;
        logic       int_ot;
        logic [1:0] ext_ot;
        logic [1:0] ext_ut;
    } tfr_status_s;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] q;
    } tfr_sync_s;

    typedef struct packed {
        logic [13:0] pre;
        logic [7:0]  cnt;
        logic        busy;
        logic        done;
    } tfr_retry_s;

    typedef struct packed {
        logic [1:0][7:0] ext_ot_act;
        logic [1:0][7:0] ext_ut_act;
        logic [7:0]      int_act;
        logic [1:0]      op_on;
        logic [1:0]      on_q;
        logic            int_q;
        logic [1:0]      ot_st;
        logic [1:0]      ut_st;
        logic            int_st;
        logic            cml_st;
        logic [1:0]      ext_off;
        logic            int_off;
        logic [1:0]      out_en;
        logic [7:0]      rd_data;
        logic            rd_valid;
    } tfr_state_s;

endpackage

// ### tfr_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module tfr_sync
    import tfr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [SYNC_W-1:0] pin,
    output logic      [SYNC_W-1:0] q
);

    tfr_sync_s s;
    tfr_sync_s next_s;

    // ================================================================
    // The first stage feeds only the second; filtering looks at two and three.
    always_comb begin
        next_s    = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.q[i] = s.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.q;

    sync_agree_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s.s2 == s.s3) |=> (q == $past(s.s3)))
        else $error("synchroniser output ignores agreeing stages");

endmodule

// ### tfr_retry.sv
// Restart interval timer: counts interval units and pulses done when it expires.
`timescale 1ns/1ps
module tfr_retry
    import tfr_pkg::*;
#(
    parameter int TICK_CYCLES = RETRY_UNIT_CYC
)(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic       cancel,
    input  wire logic [7:0] interval,
    output logic            busy,
    output logic            done
);

    tfr_retry_s s;
    tfr_retry_s next_s;

    // ================================================================
    // The unit divider yields a one-cycle tick; an interval of zero still waits one unit.
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (cancel) begin
            next_s = '0;
        end else if (start) begin
            next_s.busy = 1'b1;
            next_s.pre  = '0;
            next_s.cnt  = interval;
        end else if (s.busy) begin
            if (s.pre == 14'(TICK_CYCLES - 1)) begin
                next_s.pre = '0;
                if (s.cnt == 8'h00) begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end else begin
                next_s.pre = s.pre + 14'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
    assign done = s.done;

    retry_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        start && !cancel |=> busy && !done)
        else $error("retry timer did not start");

endmodule

// ### tfr_top.sv
// Temperature fault response: action bytes, fault status, alert and output enables.
`timescale 1ns/1ps
module tfr_top
    import tfr_pkg::*;
#(
    parameter int TICK_CYCLES = RETRY_UNIT_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire tfr_cmd_s    cmd,
    input  wire logic [1:0]  run_pin,
    input  wire logic        int_ot_pin,
    input  wire logic        conv_strobe,
    input  wire logic [1:0]  ext_ot_fault,
    input  wire logic [1:0]  ext_ut_fault,
    input  wire logic [7:0]  restart_interval_setting,
    input  wire logic [3:0]  alert_mask,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output tfr_status_s      status,
    output logic             alert_b,
    output logic      [1:0]  out_en
);

    tfr_state_s          s;
    tfr_state_s          next_s;
    logic [SYNC_W-1:0]   pins_q;
    logic [1:0]          run_q;
    logic                int_hot;
    logic [1:0]          retry_start;
    logic [1:0]          retry_done;
    logic [1:0]          on_now;
    logic [1:0]          on_rise;
    logic                int_rise;
    logic                clear_cmd;
    logic                wr;
    logic                bad_write;
    logic [1:0]          w_resp;
    logic [2:0]          w_retry;

    // ================================================================
    // Pin inputs
    tfr_sync u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   ({int_ot_pin, run_pin}),
        .q     (pins_q)
    );

    assign run_q   = pins_q[1:0];
    assign int_hot = pins_q[2];

    // ================================================================
    // Restart timers, one per page
    for (genvar p = 0; p < 2; p++) begin : g_retry
        tfr_retry #(
            .TICK_CYCLES (TICK_CYCLES)
        ) u_retry (
            .clk      (clk),
            .rst_b    (rst_b),
            .start    (retry_start[p]),
            .cancel   (!on_now[p] || clear_cmd),
            .interval (restart_interval_setting),
            .busy     (),
            .done     (retry_done[p])
        );
    end

    // ================================================================
    // Command decode
    assign wr        = cmd.valid && cmd.write;
    assign clear_cmd = wr && (cmd.code == CMD_CLEAR);
    assign w_resp    = cmd.data[RESP_HI:RESP_LO];
    assign w_retry   = cmd.data[RETRY_HI:RETRY_LO];
    assign on_now    = run_q & s.op_on;
    assign on_rise   = on_now & ~s.on_q;
    assign int_rise  = int_hot && !s.int_q;

    always_comb begin
        bad_write = 1'b0;
        if (wr && cmd.code == CMD_INT_OT) begin
            bad_write = (w_resp == RESP_CONTINUE) || (w_resp == RESP_BAD) ||
                        (w_retry != RETRY_NONE);
        end else if (wr && (cmd.code == CMD_EXT_OT || cmd.code == CMD_EXT_UT)) begin
            bad_write = (w_resp == RESP_BAD) || (w_resp == RESP_WHILE);
        end
    end

    // ================================================================
    // Retry starts when an external shutdown is taken with a nonzero retry field.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            retry_start[p] = 1'b0;
            if (conv_strobe && on_now[p] && !s.ext_off[p]) begin
                if (ext_ot_fault[p] && s.ext_ot_act[p][RESP_HI:RESP_LO] == RESP_SHUTDOWN &&
                    s.ext_ot_act[p][RETRY_HI:RETRY_LO] != RETRY_NONE) begin
                    retry_start[p] = 1'b1;
                end
                if (ext_ut_fault[p] && s.ext_ut_act[p][RESP_HI:RESP_LO] == RESP_SHUTDOWN &&
                    s.ext_ut_act[p][RETRY_HI:RETRY_LO] != RETRY_NONE) begin
                    retry_start[p] = 1'b1;
                end
            end
        end
    end

    // ================================================================
    // Next state
    always_comb begin
        next_s          = s;
        next_s.rd_valid = 1'b0;
        next_s.on_q     = on_now;
        next_s.int_q    = int_hot;

        // Register writes; a rejected value leaves the old byte in place.
        if (wr && !bad_write) begin
            unique case (cmd.code)
                CMD_EXT_OT: next_s.ext_ot_act[cmd.page] = cmd.data;
                CMD_EXT_UT: next_s.ext_ut_act[cmd.page] = cmd.data;
                CMD_INT_OT: next_s.int_act = cmd.data;
                CMD_OPERATION: next_s.op_on[cmd.page] = cmd.data[OP_ON_BIT];
                default: next_s.rd_valid = 1'b0;
            endcase
        end

        // Clears come first so that a fault in the same cycle still sets.
        if (clear_cmd) begin
            next_s.ot_st   = '0;
            next_s.ut_st   = '0;
            next_s.int_st  = 1'b0;
            next_s.cml_st  = 1'b0;
            next_s.ext_off = '0;
            next_s.int_off = 1'b0;
        end
        for (int p = 0; p < 2; p++) begin
            if (on_rise[p]) begin
                next_s.ot_st[p]   = 1'b0;
                next_s.ut_st[p]   = 1'b0;
                next_s.ext_off[p] = 1'b0;
            end
        end
        if (|on_rise) begin
            next_s.int_st  = 1'b0;
            next_s.int_off = 1'b0;
        end

        // Unsupported write logs a comms fault.
        if (bad_write) begin
            next_s.cml_st = 1'b1;
        end

        if (int_rise) begin
            next_s.int_st = 1'b1;
            if (s.int_act[RESP_HI:RESP_LO] == RESP_SHUTDOWN) begin
                next_s.int_off = 1'b1;
            end
        end

        for (int p = 0; p < 2; p++) begin
            if (retry_done[p] && on_now[p]) begin
                next_s.ext_off[p] = 1'b0;
            end
            // External faults seen only at samples.
            if (conv_strobe) begin
                if (ext_ot_fault[p]) begin
                    next_s.ot_st[p] = 1'b1;
                    if (s.ext_ot_act[p][RESP_HI:RESP_LO] == RESP_SHUTDOWN) begin
                        next_s.ext_off[p] = 1'b1;
                    end
                end
                if (ext_ut_fault[p]) begin
                    next_s.ut_st[p] = 1'b1;
                    if (s.ext_ut_act[p][RESP_HI:RESP_LO] == RESP_SHUTDOWN) begin
                        next_s.ext_off[p] = 1'b1;
                    end
                end
            end
        end

        // Code 11 holds off only while hot.
        for (int p = 0; p < 2; p++) begin
            next_s.out_en[p] = on_now[p] && !next_s.ext_off[p] && !next_s.int_off &&
                !(s.int_act[RESP_HI:RESP_LO] == RESP_WHILE && int_hot);
        end

        // Action-byte reads return the whole byte; the delay field steers nothing.
        if (cmd.valid && !cmd.write) begin
            next_s.rd_valid = 1'b1;
            unique case (cmd.code)
                CMD_EXT_OT:      next_s.rd_data = s.ext_ot_act[cmd.page];
                CMD_EXT_UT:      next_s.rd_data = s.ext_ut_act[cmd.page];
                CMD_INT_OT:      next_s.rd_data = s.int_act;
                CMD_OPERATION:   next_s.rd_data = {s.op_on[cmd.page], 7'h00};
                CMD_STATUS_BYTE: next_s.rd_data = {5'h00,
                    s.ot_st[cmd.page] | s.ut_st[cmd.page], s.cml_st, s.int_st};
                CMD_STATUS_TEMP: next_s.rd_data = {s.ot_st[cmd.page], s.ut_st[cmd.page],
                    6'h00};
                CMD_STATUS_MFR:  next_s.rd_data = {6'h00, s.int_st, 1'b0};
                default:         next_s.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s            <= '0;
            s.ext_ot_act <= {EXT_ACT_RESET, EXT_ACT_RESET};
            s.ext_ut_act <= {EXT_ACT_RESET, EXT_ACT_RESET};
            s.int_act    <= INT_ACT_RESET;
            s.op_on      <= {OP_ON_RESET, OP_ON_RESET};
        end else begin
            s <= next_s;
        end
    end

    // ================================================================
    // Outputs
    always_comb begin
        status.int_ot                = s.int_st;
        status.catch_all_status_flag = s.int_st;
        status.mfr_summary           = s.int_st;
        status.cml                   = s.cml_st;
        status.temp_summary          = |{s.ot_st, s.ut_st};
        status.ext_ot                = s.ot_st;
        status.ext_ut                = s.ut_st;
    end

    // Alert unless the source is masked.
    assign alert_b = !((s.cml_st && !alert_mask[MASK_CML]) ||
                       (s.int_st && !alert_mask[MASK_INT]) ||
                       ((|s.ot_st) && !alert_mask[MASK_OT]) ||
                       ((|s.ut_st) && !alert_mask[MASK_UT]));
    assign rd_data  = s.rd_data;
    assign rd_valid = s.rd_valid;
    assign out_en   = s.out_en;

    // ================================================================
    // Checks
    int_shut_a: assert property (@(posedge clk) disable iff (!rst_b)
        int_rise && s.int_act[7:6] == 2'h2 |=> s.int_off ##1 out_en == 2'h0)
        else $error("internal shutdown not taken");
    hot_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        s.int_act[7:6] == 2'h3 && int_hot |=> out_en == 2'h0)
        else $error("output on while hot under code 11");
    int_bad_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr && cmd.code == CMD_INT_OT && cmd.data[7] == 1'b0 |=>
        s.cml_st && s.int_act == $past(s.int_act))
        else $error("unsupported internal code accepted");
    ext_bad_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr && cmd.code == CMD_EXT_OT && cmd.data[6] == 1'b1 |=>
        s.cml_st && s.ext_ot_act == $past(s.ext_ot_act))
        else $error("unsupported external code accepted");
    ot_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        conv_strobe && ext_ot_fault[0] |=> s.ot_st[0] && status.temp_summary)
        else $error("external overtemperature not logged");
    ot_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
        s.ot_st[0] && !clear_cmd && !on_rise[0] |=> s.ot_st[0])
        else $error("latched status dropped without a clear");
    cml_alert_a: assert property (@(posedge clk) disable iff (!rst_b)
        bad_write && !alert_mask[MASK_CML] |=> !alert_b)
        else $error("comms fault did not alert");
    cont_run_a: assert property (@(posedge clk) disable iff (!rst_b)
        s.ext_ut_act[0][7:6] == 2'h0 && !s.ext_off[0] && conv_strobe && ext_ut_fault[0] &&
        !(ext_ot_fault[0] && s.ext_ot_act[0][7:6] == 2'h2) |=> !s.ext_off[0])
        else $error("code 00 interrupted the output");

endmodule

// ### tfr_host.sv
// Host model that issues single-byte commands and collects read answers.
`timescale 1ns/1ps
module tfr_host
    import tfr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output tfr_cmd_s        cmd
);
    // ================================================================
    // Command issue
    initial begin
        cmd = '{1'b0, 1'b0, 1'b0, 8'hff, 8'hff};
    end

    // One command per call; valid stands for exactly one rising edge.
    task automatic issue(input logic w, input logic pg, input logic [7:0] code,
                         input logic [7:0] data);
        @(negedge clk);
        cmd = '{1'b1, w, pg, code, data};
        @(negedge clk);
        // Idle fields are inverted so a stale command never looks valid.
        cmd = '{1'b0, ~w, ~pg, ~code, ~data};
    endtask

    // The answer stands only for the cycle after the command edge, so it is
    // taken at the falling edge that ends the command, before it drops again.
    task automatic read(input logic pg, input logic [7:0] code,
                        output logic [7:0] data, output logic ok);
        issue(1'b0, pg, code, 8'h00);
        ok = rd_valid;
        data = rd_data;
    endtask
endmodule

// ### test_temperature_fault_response.sv
// Self-checking bench for the temperature fault response block.
`timescale 1ns/1ps
module test_temperature_fault_response;
    import tfr_pkg::*;
    // Short interval unit keeps restart waits brief.
    localparam int TICK = 4;
    logic        clk;
    logic        rst_b;
    tfr_cmd_s    cmd;
    logic [1:0]  run_pin;
    logic        int_ot_pin;
    logic        conv_strobe;
    logic [1:0]  ext_ot_fault;
    logic [1:0]  ext_ut_fault;
    logic [7:0]  restart_interval_setting;
    logic [3:0]  alert_mask;
    logic [7:0]  rd_data;
    logic        rd_valid;
    tfr_status_s status;
    logic        alert_b;
    logic [1:0]  out_en;
    int          fails;
    int          num_checks;
    logic [31:0] seed;
    logic [7:0]  model_reg [0:511];

    tfr_top #(.TICK_CYCLES(TICK)) u_dut (.clk(clk), .rst_b(rst_b), .cmd(cmd),
        .run_pin(run_pin), .int_ot_pin(int_ot_pin), .conv_strobe(conv_strobe),
        .ext_ot_fault(ext_ot_fault), .ext_ut_fault(ext_ut_fault),
        .restart_interval_setting(restart_interval_setting), .alert_mask(alert_mask),
        .rd_data(rd_data), .rd_valid(rd_valid), .status(status), .alert_b(alert_b),
        .out_en(out_en));
    tfr_host u_host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd));

    // ================================================================
    // Helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic rdchk(input logic pg, input logic [7:0] code);
        logic [7:0] d;
        logic       ok;
        u_host.read(pg, code, d, ok);
        chk("rd_valid", 8'h01, 8'(ok));
        chk("rd_data", model_reg[{pg, code}], d);
    endtask

    task automatic clr();
        u_host.issue(1'b1, 1'b0, CMD_CLEAR, 8'h00);
        @(posedge clk);
        #1;
    endtask

    // The model keeps a byte only if its field codes are supported.
    task automatic wr(input logic pg, input logic [7:0] code, input logic [7:0] d);
        logic ok;
        ok = (code == CMD_INT_OT) ? (d[7] && d[5:3] == 3'h0) : !d[6];
        if (ok) model_reg[{pg, code}] = d;
        u_host.issue(1'b1, pg, code, d);
        @(posedge clk);
        #1;
        chk("cml", 8'(!ok), 8'(status.cml));
        chk("alert_b", 8'(ok), 8'(alert_b));
        clr();
    endtask

    task automatic sample(input logic [1:0] ot, input logic [1:0] ut);
        @(negedge clk);
        {conv_strobe, ext_ot_fault, ext_ut_fault} = {1'b1, ot, ut};
        @(negedge clk);
        {conv_strobe, ext_ot_fault, ext_ut_fault} = '0;
        @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ================================================================
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #400000;
        fails++;
        report_and_stop();
    end

    initial begin
        int         n;
        int         cnt;
        logic [7:0] r;
        seed = 32'hd29b;
        rst_b = 1'b0;
        run_pin = 2'b11;
        {int_ot_pin, conv_strobe, ext_ot_fault, ext_ut_fault} = '0;
        restart_interval_setting = 8'h00;
        alert_mask = 4'h0;
        foreach (model_reg[i]) model_reg[i] = 8'h00;
        for (int p = 0; p < 2; p++) begin
            model_reg[{p[0], CMD_EXT_OT}] = 8'hb8;
            model_reg[{p[0], CMD_EXT_UT}] = 8'hb8;
        end
        model_reg[{1'b0, CMD_INT_OT}] = 8'hc0;
        cyc(12);
        rst_b = 1'b1;
        cyc(8);
        chk("out_en", 8'h03, 8'(out_en));
        chk("alert_b", 8'h01, 8'(alert_b));
        for (int p = 0; p < 2; p++) begin
            rdchk(p[0], CMD_EXT_OT);
            rdchk(p[0], CMD_EXT_UT);
        end
        rdchk(1'b0, CMD_INT_OT);
        rdchk(1'b0, 8'h5a);
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            wr(r[7], i[2] ? CMD_EXT_UT : CMD_EXT_OT, {i[1:0], r[5:0]});
            rdchk(r[7], i[2] ? CMD_EXT_UT : CMD_EXT_OT);
        end
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            wr(1'b0, CMD_INT_OT, {i[1:0], (i < 4) ? 3'h0 : 3'(i - 3), r[2:0]});
            rdchk(1'b0, CMD_INT_OT);
        end
        wr(1'b0, CMD_INT_OT, {5'h10, r[2:0]});
        wr(1'b0, CMD_EXT_OT, 8'hb8);
        wr(1'b1, CMD_EXT_OT, 8'hb8);
        wr(1'b0, CMD_EXT_UT, 8'h38);
        $display("test command_writes done");
        cyc(1);
        r = rnd();
        n = int'(r[1:0]);
        restart_interval_setting = {6'h00, r[1:0]};
        ext_ot_fault = 2'b01;
        cyc(3);
        chk("ext_ot_no_strobe", 8'h00, 8'(status.ext_ot));
        sample(2'b01, 2'b00);
        chk("ext_ot", 8'h01, 8'(status.ext_ot));
        chk("temp_summary", 8'h01, 8'(status.temp_summary));
        chk("alert_b", 8'h00, 8'(alert_b));
        chk("out_en", 8'h02, 8'(out_en));
        cnt = 0;
        while (out_en[0] !== 1'b1 && cnt < 100) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        chk("retry_window", 8'h01, 8'(cnt >= (n + 1) * TICK - 2 && cnt <= (n + 1) * TICK + 2));
        chk("ext_ot_sticky", 8'h01, 8'(status.ext_ot));
        model_reg[{1'b0, CMD_STATUS_BYTE}] = 8'h04;
        model_reg[{1'b0, CMD_STATUS_TEMP}] = 8'h80;
        rdchk(1'b0, CMD_STATUS_BYTE);
        rdchk(1'b0, CMD_STATUS_TEMP);
        clr();
        chk("ext_ot_clear", 8'h00, 8'(status.ext_ot));
        cyc(1);
        alert_mask = 4'h4;
        sample(2'b10, 2'b00);
        chk("ext_ot_masked", 8'h02, 8'(status.ext_ot));
        chk("alert_masked", 8'h01, 8'(alert_b));
        cyc(1);
        alert_mask = 4'h0;
        #1;
        chk("alert_unmasked", 8'h00, 8'(alert_b));
        clr();
        $display("test external_overtemperature done");
        sample(2'b00, 2'b01);
        chk("ext_ut", 8'h01, 8'(status.ext_ut));
        chk("temp_summary", 8'h01, 8'(status.temp_summary));
        chk("out_en_runs_on", 8'h03, 8'(out_en));
        cyc(1);
        run_pin = 2'b10;
        cyc(8);
        run_pin = 2'b11;
        cyc(8);
        chk("ext_ut_off_on", 8'h00, 8'(status.ext_ut));
        // Off-then-on through the operation command clears the page as well.
        sample(2'b00, 2'b01);
        u_host.issue(1'b1, 1'b0, CMD_OPERATION, 8'h00);
        cyc(1);
        chk("out_en_op_off", 8'h02, 8'(out_en));
        chk("ext_ut_op_off", 8'h01, 8'(status.ext_ut));
        model_reg[{1'b0, CMD_OPERATION}] = 8'h00;
        rdchk(1'b0, CMD_OPERATION);
        u_host.issue(1'b1, 1'b0, CMD_OPERATION, 8'h80);
        cyc(1);
        chk("ext_ut_op_on", 8'h00, 8'(status.ext_ut));
        $display("test external_undertemperature done");
        int_ot_pin = 1'b1;
        cyc(8);
        chk("int_ot", 8'h01, 8'(status.int_ot));
        chk("catch_all", 8'h01, 8'(status.catch_all_status_flag));
        chk("mfr_summary", 8'h01, 8'(status.mfr_summary));
        chk("out_en_off", 8'h00, 8'(out_en));
        model_reg[{1'b0, CMD_STATUS_MFR}] = 8'h02;
        model_reg[{1'b0, CMD_STATUS_BYTE}] = 8'h01;
        rdchk(1'b0, CMD_STATUS_MFR);
        rdchk(1'b0, CMD_STATUS_BYTE);
        int_ot_pin = 1'b0;
        cyc(8);
        chk("out_en_held", 8'h00, 8'(out_en));
        clr();
        cyc(3);
        chk("int_ot_clear", 8'h00, 8'(status.int_ot));
        chk("out_en_back", 8'h03, 8'(out_en));
        wr(1'b0, CMD_INT_OT, 8'hc0);
        cyc(1);
        int_ot_pin = 1'b1;
        cyc(8);
        chk("out_en_hot", 8'h00, 8'(out_en));
        int_ot_pin = 1'b0;
        cyc(8);
        chk("out_en_cool", 8'h03, 8'(out_en));
        $display("test internal_overtemperature done");
        report_and_stop();
    end
endmodule
